/* File: hdl/vm_entry_pkg.sv */
// Package of constants, types and register map for the VM entry completion block
package vm_entry_pkg;
	localparam logic [11:0] ADDR_ENTRY_INFO = 12'h000;
	localparam logic [11:0] ADDR_INTR_STATE = 12'h004;
	localparam logic [11:0] ADDR_ACT_STATE = 12'h008;
	localparam logic [11:0] ADDR_CONTROLS = 12'h00c;
	localparam logic [11:0] ADDR_TABLE_BASE = 12'h010;
	localparam logic [11:0] ADDR_COMMAND = 12'h014;
	localparam logic [11:0] ADDR_BLOCK_STAT = 12'h018;
	localparam logic [11:0] ADDR_EXIT_STAT = 12'h01c;
	localparam logic [11:0] ADDR_VECTORING = 12'h020;
	localparam logic [11:0] ADDR_FETCH_ADDR = 12'h024;
	localparam logic [11:0] ADDR_EVENTS = 12'h028;
	localparam int INFO_VALID_BIT = 31;
	localparam int INFO_ERRCODE_BIT = 11;
	localparam int INFO_TYPE_LSB = 8;
	localparam int INTR_STI_BIT = 0;
	localparam int INTR_MOVSS_BIT = 1;
	localparam int INTR_SMI_BIT = 2;
	localparam int INTR_NMI_BIT = 3;
	localparam int CTL_PE_BIT = 0;
	localparam int CTL_VNMI_BIT = 1;
	localparam int CTL_NMI_EXIT_BIT = 2;
	localparam int CTL_SMM_BIT = 3;
	localparam int CTL_SMX_BIT = 4;
	localparam int CTL_EXTINT_EXIT_BIT = 5;
	localparam int CMD_ENTRY_BIT = 0;
	localparam int CMD_STEP_BIT = 1;
	localparam int CMD_EXC_BIT = 2;
	localparam int CMD_INTERRUPT_RETURN_BIT = 3;
	localparam logic [2:0] TYPE_EXT = 3'h0;
	localparam logic [2:0] TYPE_NMI = 3'h2;
	localparam logic [2:0] TYPE_HW = 3'h3;
	localparam logic [2:0] TYPE_SWI = 3'h4;
	localparam logic [2:0] TYPE_PSW = 3'h5;
	localparam logic [2:0] TYPE_SWE = 3'h6;
	localparam logic [2:0] TYPE_OTHER = 3'h7;
	localparam logic [7:0] MTF_VECTOR = 8'h00;
	localparam logic [15:0] SHUTDOWN_CODE = 16'h0000;
	localparam logic [31:0] ENTRY_BYTES = 32'h4;
	localparam logic [1:0] ACT_ACTIVE = 2'h0;
	localparam logic [1:0] ACT_HALT = 2'h1;
	localparam logic [1:0] ACT_SHUTDOWN = 2'h2;
	localparam logic [1:0] ACT_WAIT_STARTUP_INTERPROCESSOR_INTERRUPT = 2'h3;
	localparam logic [3:0] EXIT_NONE = 4'h0;
	localparam logic [3:0] EXIT_EXCEPTION = 4'h1;
	localparam logic [3:0] EXIT_TRIPLE = 4'h2;
	localparam logic [3:0] EXIT_TASK = 4'h3;
	localparam logic [3:0] EXIT_MTF = 4'h4;
	typedef struct packed {
		logic interrupt_enable_shadow;
		logic movss;
		logic nmi;
		logic vnmi;
		logic management_interrupt;
	} blocking_t;
	typedef struct packed {
		logic ext_int;
		logic nmi;
		logic init;
		logic management_interrupt;
		logic startup_interprocessor_interrupt;
	} events_t;
	typedef struct packed {
		logic task_gate_exit;
		logic nested_exc;
		logic [4:0] nested_vec;
		logic second_exc;
		logic [4:0] second_vec;
		logic df_injected;
		logic limit_fault;
	} delivery_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_DELIVER = 3'b010,
		ST_DONE = 3'b100
	} entry_state_t;
endpackage

/* File: hdl/vm_entry_event_blocking_state.sv */
// VM entry completion: injection exits, vectoring, post-entry blocking and activity state
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module vm_entry_event_blocking_state (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire vm_entry_pkg::delivery_t delivery_in,
	input wire logic [31:0] exception_bitmap_in,
	input wire vm_entry_pkg::events_t events_in,
	output vm_entry_pkg::blocking_t blocking_out,
	output logic [1:0] activity_out,
	output vm_entry_pkg::events_t blocked_out,
	output logic special_cycle_out,
	output logic smx_shutdown_out,
	output logic [15:0] smx_code_out,
	output logic mtf_pending_out,
	output logic vm_exit_out,
	output logic [3:0] exit_reason_out,
	output logic [31:0] fetch_addr_out,
	output logic fetch_out,
	output logic push_errcode_out,
	output logic entry_done_out
);
	import vm_entry_pkg::*;

	logic [31:0] info_q, info_d;
	logic [3:0] intr_q, intr_d;
	logic [1:0] act_req_q, act_req_d;
	logic [5:0] ctl_q, ctl_d;
	logic [31:0] base_q, base_d;
	entry_state_t st_q, st_d;
	blocking_t blk_q, blk_d;
	logic [1:0] act_q, act_d;
	logic vect_q, vect_d;
	logic mtf_q, mtf_d;
	logic exit_q, exit_d;
	logic [3:0] reason_q, reason_d;
	logic [31:0] vect_info_q, vect_info_d;
	logic [31:0] faddr_q, faddr_d;
	logic fetch_q, fetch_d;
	logic push_q, push_d;
	logic spc_q, spc_d;
	logic smx_q, smx_d;
	logic done_q, done_d;
	events_t seen_q, seen_d;
	logic [31:0] rdata_d, rdata_q;

	logic wr_en;
	logic [2:0] itype;
	logic [7:0] ivec;
	logic ivalid;
	logic vectoring;
	logic nested_exits;
	logic second_exits;
	logic deliver_fault;
	events_t blocked;

	assign wr_en = psel_in && penable_in && pwrite_in;
	assign itype = info_q[INFO_TYPE_LSB +: 3];
	assign ivec = info_q[7:0];
	assign ivalid = info_q[INFO_VALID_BIT];
	assign vectoring = ivalid && (itype == TYPE_EXT || itype == TYPE_NMI || itype == TYPE_HW ||
		itype == TYPE_SWI || itype == TYPE_PSW || itype == TYPE_SWE);
	assign deliver_fault = delivery_in.nested_exc || (!ctl_q[CTL_PE_BIT] && delivery_in.limit_fault);
	assign nested_exits = deliver_fault && exception_bitmap_in[delivery_in.nested_vec];
	assign second_exits = delivery_in.second_exc && exception_bitmap_in[delivery_in.second_vec];

	always_comb begin
		blocked = '0;
		unique case (act_q)
			ACT_ACTIVE, ACT_HALT: begin
				blocked.startup_interprocessor_interrupt = 1'b1;
			end
			ACT_SHUTDOWN: begin
				blocked.ext_int = 1'b1;
				blocked.startup_interprocessor_interrupt = 1'b1;
			end
			ACT_WAIT_STARTUP_INTERPROCESSOR_INTERRUPT: begin
				blocked.ext_int = 1'b1;
				blocked.nmi = 1'b1;
				blocked.init = 1'b1;
				blocked.management_interrupt = 1'b1;
			end
		endcase
		blocked.nmi = blocked.nmi | blk_q.nmi;
		blocked.management_interrupt = blocked.management_interrupt | blk_q.management_interrupt;
	end

	// Guest state fields loaded by software
	always_comb begin
		info_d = info_q;
		intr_d = intr_q;
		act_req_d = act_req_q;
		ctl_d = ctl_q;
		base_d = base_q;
		if (wr_en) begin
			unique case (paddr_in)
				ADDR_ENTRY_INFO: info_d = pwdata_in;
				ADDR_INTR_STATE: intr_d = pwdata_in[3:0];
				ADDR_ACT_STATE: act_req_d = pwdata_in[1:0];
				ADDR_CONTROLS: ctl_d = pwdata_in[5:0];
				ADDR_TABLE_BASE: base_d = pwdata_in;
				default: ;
			endcase
		end
	end

	// Sticky log of blocked events, set wins over clear
	always_comb begin
		seen_d = seen_q | (events_in & blocked);
		if (wr_en && paddr_in == ADDR_EVENTS) begin
			seen_d = (seen_q & ~pwdata_in[4:0]) | (events_in & blocked);
		end
	end

	// Entry sequencer
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			ST_IDLE: begin
				if (wr_en && paddr_in == ADDR_COMMAND && pwdata_in[CMD_ENTRY_BIT]) begin
					st_d = ST_DELIVER;
				end
			end
			ST_DELIVER: st_d = ST_DONE;
			ST_DONE: st_d = ST_IDLE;
			default: st_d = ST_IDLE;
		endcase
	end

	// Entry outcomes and guest progress commands
	always_comb begin
		blk_d = blk_q;
		act_d = act_q;
		vect_d = vect_q;
		mtf_d = mtf_q;
		exit_d = 1'b0;
		reason_d = reason_q;
		vect_info_d = vect_info_q;
		faddr_d = faddr_q;
		fetch_d = 1'b0;
		push_d = 1'b0;
		spc_d = 1'b0;
		smx_d = 1'b0;
		done_d = 1'b0;
		if (wr_en && paddr_in == ADDR_COMMAND) begin
			if (pwdata_in[CMD_STEP_BIT] || pwdata_in[CMD_EXC_BIT]) begin
				blk_d.interrupt_enable_shadow = 1'b0;
				blk_d.movss = 1'b0;
			end
			if (pwdata_in[CMD_INTERRUPT_RETURN_BIT]) begin
				if (ctl_q[CTL_VNMI_BIT]) begin
					blk_d.vnmi = 1'b0;
				end else if (!ctl_q[CTL_NMI_EXIT_BIT]) begin
					blk_d.nmi = 1'b0;
				end
			end
		end
		unique case (st_q)
			ST_IDLE: ;
			ST_DELIVER: begin
				// No exit is ever raised by the injected event's own type or controls
				vect_d = vectoring;
				if (vectoring && !ctl_q[CTL_PE_BIT]) begin
					faddr_d = base_q + 32'(ivec) * ENTRY_BYTES;
					fetch_d = 1'b1;
				end
				push_d = vectoring && ctl_q[CTL_PE_BIT] && info_q[INFO_ERRCODE_BIT];
				if (vectoring && (delivery_in.task_gate_exit || nested_exits)) begin
					exit_d = 1'b1;
					reason_d = delivery_in.task_gate_exit ? EXIT_TASK : EXIT_EXCEPTION;
					vect_info_d = info_q;
				end else if (vectoring && deliver_fault &&
					(delivery_in.df_injected || delivery_in.second_exc) && !second_exits) begin
					exit_d = 1'b1;
					reason_d = EXIT_TRIPLE;
				end else if (vectoring && deliver_fault && second_exits) begin
					exit_d = 1'b1;
					reason_d = EXIT_EXCEPTION;
				end
			end
			ST_DONE: begin
				// Every entry's blocking and activity outcome lands on this one boundary; commands clear blocking bits in any state but this one, where the outcome wins
				done_d = 1'b1;
				mtf_d = ivalid && itype == TYPE_OTHER && ivec == MTF_VECTOR;
				if (mtf_d) begin
					reason_d = EXIT_MTF;
				end
				blk_d.interrupt_enable_shadow = !vect_q && intr_q[INTR_STI_BIT];
				blk_d.movss = !vect_q && intr_q[INTR_MOVSS_BIT];
				blk_d.nmi = !ctl_q[CTL_VNMI_BIT] && intr_q[INTR_NMI_BIT];
				blk_d.vnmi = ctl_q[CTL_VNMI_BIT] && (intr_q[INTR_NMI_BIT] ||
					(vect_q && itype == TYPE_NMI));
				if (ctl_q[CTL_SMM_BIT]) begin
					blk_d.management_interrupt = intr_q[INTR_SMI_BIT];
				end
				act_d = vect_q ? ACT_ACTIVE : act_req_q;
				spc_d = !vect_q && act_req_q != ACT_ACTIVE;
				smx_d = !vect_q && act_req_q == ACT_SHUTDOWN && ctl_q[CTL_SMX_BIT];
			end
			default: ;
		endcase
		if (st_q == ST_IDLE && mtf_q && wr_en && paddr_in == ADDR_COMMAND && pwdata_in[CMD_STEP_BIT]) begin
			mtf_d = 1'b0;
		end
	end

	// Read data captured in the setup cycle, held through access
	always_comb begin
		rdata_d = rdata_q;
		if (psel_in && !penable_in && !pwrite_in) begin
			unique case (paddr_in)
				ADDR_ENTRY_INFO: rdata_d = info_q;
				ADDR_INTR_STATE: rdata_d = {28'h0, intr_q};
				ADDR_ACT_STATE: rdata_d = {30'h0, act_req_q};
				ADDR_CONTROLS: rdata_d = {26'h0, ctl_q};
				ADDR_TABLE_BASE: rdata_d = base_q;
				ADDR_BLOCK_STAT: rdata_d = {23'h0, st_q == ST_IDLE, vect_q, act_q, blk_q};
				ADDR_EXIT_STAT: rdata_d = {26'h0, mtf_q, exit_q, reason_q};
				ADDR_VECTORING: rdata_d = vect_info_q;
				ADDR_FETCH_ADDR: rdata_d = faddr_q;
				ADDR_EVENTS: rdata_d = {27'h0, seen_q};
				default: rdata_d = 32'h0;
			endcase
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			info_q <= 32'h0;
			intr_q <= 4'h0;
			act_req_q <= ACT_ACTIVE;
			ctl_q <= 6'h01;
			base_q <= 32'h0;
		end else begin
			info_q <= info_d;
			intr_q <= intr_d;
			act_req_q <= act_req_d;
			ctl_q <= ctl_d;
			base_q <= base_d;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			seen_q <= '0;
		end else begin
			seen_q <= seen_d;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_q <= ST_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	// Post-entry state that stands until the next entry or command
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			blk_q <= '0;
			act_q <= ACT_ACTIVE;
			vect_q <= 1'b0;
			mtf_q <= 1'b0;
			reason_q <= EXIT_NONE;
			vect_info_q <= 32'h0;
			faddr_q <= 32'h0;
		end else begin
			blk_q <= blk_d;
			act_q <= act_d;
			vect_q <= vect_d;
			mtf_q <= mtf_d;
			reason_q <= reason_d;
			vect_info_q <= vect_info_d;
			faddr_q <= faddr_d;
		end
	end

	// One-cycle pulses
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			exit_q <= 1'b0;
			fetch_q <= 1'b0;
			push_q <= 1'b0;
			spc_q <= 1'b0;
			smx_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			exit_q <= exit_d;
			fetch_q <= fetch_d;
			push_q <= push_d;
			spc_q <= spc_d;
			smx_q <= smx_d;
			done_q <= done_d;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_q <= 32'h0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign prdata_out = rdata_q;
	assign pready_out = 1'b1;
	assign pslverr_out = 1'b0;
	assign blocking_out = blk_q;
	assign activity_out = act_q;
	assign blocked_out = blocked;
	assign special_cycle_out = spc_q;
	assign smx_shutdown_out = smx_q;
	assign smx_code_out = SHUTDOWN_CODE;
	assign mtf_pending_out = mtf_q;
	assign vm_exit_out = exit_q;
	assign exit_reason_out = reason_q;
	assign fetch_addr_out = faddr_q;
	assign fetch_out = fetch_q;
	assign push_errcode_out = push_q;
	assign entry_done_out = done_q;
endmodule
`default_nettype wire

/* File: dv/vm_entry_props.sv */
// Checker of post-entry outputs
`timescale 1ns/1ns
`default_nettype none
module vm_entry_props (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire vm_entry_pkg::blocking_t blocking_out,
	input wire logic [1:0] activity_out,
	input wire vm_entry_pkg::events_t blocked_out,
	input wire logic special_cycle_out,
	input wire logic smx_shutdown_out,
	input wire logic [15:0] smx_code_out,
	input wire logic vm_exit_out,
	input wire logic entry_done_out
);
	import vm_entry_pkg::*;
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	smx_code_a: assert property (smx_shutdown_out |-> smx_code_out == 16'h0000) else $error("bad code");
	smx_state_a: assert property (smx_shutdown_out |-> activity_out == 2'h2) else $error("bad state");
	exit_done_a: assert property (vm_exit_out |=> entry_done_out) else $error("exit late");
	special_cyc_a: assert property (special_cycle_out |-> entry_done_out && activity_out != 2'h0) else $error("cycle");
	act_change_a: assert property ($changed(activity_out) |-> entry_done_out) else $error("act moved");
	startup_interprocessor_interrupt_drop_a: assert property (activity_out != 2'h3 |-> blocked_out.startup_interprocessor_interrupt) else $error("startup_interprocessor_interrupt");
	shut_block_a: assert property (activity_out == 2'h2 |-> blocked_out.ext_int) else $error("ext");
	wait_block_a: assert property (activity_out == 2'h3 |-> blocked_out[4:1] == 4'hf) else $error("wait");
	nmi_block_a: assert property (blocking_out.nmi |-> blocked_out.nmi) else $error("nmi");
	cover property (vm_exit_out);
	cover property (smx_shutdown_out);
	cover property (activity_out == 2'h3);
endmodule
bind vm_entry_event_blocking_state vm_entry_props i_props (.mclk_in, .rst_n_in, .blocking_out, .activity_out,
	.blocked_out, .special_cycle_out, .smx_shutdown_out, .smx_code_out, .vm_exit_out, .entry_done_out);
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the VM entry completion block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import vm_entry_pkg::*;
	logic mclk_in = 0, rst_n_in = 0, psel = 0, pen = 0, pwr = 0, mtf_m = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, bmap = 0, fa, ctl_m = 1;
	logic prdy, perr, spc, secure_mode_extension, monitor_trap, vx, ft, pe, dn;
	logic [15:0] code;
	logic [3:0] rsn;
	logic [1:0] act, act_m = 0;
	delivery_t dlv = '0;
	events_t ev = '0, blkd;
	blocking_t blk, blk_m = '0;
	int error_cnt = 0, compares = 0;
	always #50 mclk_in = ~mclk_in;
	vm_entry_event_blocking_state i_dut (.mclk_in, .rst_n_in, .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
		.paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(prdy), .pslverr_out(perr),
		.delivery_in(dlv), .exception_bitmap_in(bmap), .events_in(ev), .blocking_out(blk), .activity_out(act),
		.blocked_out(blkd), .special_cycle_out(spc), .smx_shutdown_out(secure_mode_extension), .smx_code_out(code),
		.mtf_pending_out(monitor_trap), .vm_exit_out(vx), .exit_reason_out(rsn), .fetch_addr_out(fa), .fetch_out(ft),
		.push_errcode_out(pe), .entry_done_out(dn));
	task automatic end_sim;
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge mclk_in);
		psel <= 1;
		pen <= 0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk_in);
		pen <= 1;
		@(posedge mclk_in);
		while (prdy !== 1'b1) @(posedge mclk_in);
		r = prdata;
		psel <= 0;
		pen <= 0;
	endtask
	task automatic entry(input logic [31:0] info, input logic [31:0] intr, input logic [1:0] ra,
		input logic [31:0] ctl, input logic [31:0] base);
		logic [31:0] r;
		logic [2:0] ty;
		logic vect, xe, f, p, sm, sp, flt, v4;
		logic [3:0] xr;
		int n;
		apb(1, ADDR_ENTRY_INFO, info, r);
		apb(1, ADDR_INTR_STATE, intr, r);
		apb(1, ADDR_ACT_STATE, {30'h0, ra}, r);
		apb(1, ADDR_CONTROLS, ctl, r);
		apb(1, ADDR_TABLE_BASE, base, r);
		apb(1, ADDR_COMMAND, 32'h1, r);
		ty = info[10:8];
		vect = info[31] && ty != 3'h1 && ty != 3'h7;
		flt = dlv.nested_exc || (!ctl[0] && dlv.limit_fault);
		v4 = vect && (dlv.task_gate_exit || (flt && bmap[dlv.nested_vec]));
		xr = EXIT_NONE;
		if (vect && dlv.task_gate_exit) xr = EXIT_TASK;
		else if (vect && flt) begin
			if (bmap[dlv.nested_vec]) xr = EXIT_EXCEPTION;
			else if (dlv.second_exc && bmap[dlv.second_vec]) xr = EXIT_EXCEPTION;
			else if (dlv.second_exc || dlv.df_injected) xr = EXIT_TRIPLE;
		end
		{f, p, xe, sp, sm} = '0;
		n = 0;
		do begin
			@(posedge mclk_in);
			#1;
			{f, p, xe, sp, sm} = {f, p, xe, sp, sm} | {ft, pe, vx, spc, secure_mode_extension};
			n++;
		end while (dn !== 1'b1 && n < 10);
		ctl_m = ctl;
		blk_m.interrupt_enable_shadow = !vect && intr[0];
		blk_m.movss = !vect && intr[1];
		blk_m.nmi = !ctl[1] && intr[3];
		blk_m.vnmi = ctl[1] && (intr[3] || vect && ty == TYPE_NMI);
		if (ctl[3]) blk_m.management_interrupt = intr[2];
		act_m = vect ? ACT_ACTIVE : ra;
		mtf_m = info[31] && ty == TYPE_OTHER && info[7:0] == MTF_VECTOR;
		chk(dn, 1, "done");
		chk(blk, blk_m, "blocking");
		chk(act, act_m, "activity");
		chk(xe, xr != EXIT_NONE, "exit");
		if (xr != EXIT_NONE) chk(rsn, xr, "reason");
		if (v4) apb(0, ADDR_VECTORING, 0, r);
		if (v4) chk(r, info, "vect info");
		chk(f, vect && !ctl[0], "fetch");
		if (vect && !ctl[0]) chk(fa, base + {info[7:0], 2'b00}, "addr");
		chk(p, vect && ctl[0] && info[11], "push");
		chk(sp, !vect && ra != ACT_ACTIVE, "special");
		chk(sm, !vect && ra == ACT_SHUTDOWN && ctl[4], "smx");
		chk(monitor_trap, mtf_m, "mtf");
		chk({blkd.ext_int, blkd.init, blkd.startup_interprocessor_interrupt}, {act_m[1], act_m == 2'h3, act_m != 2'h3}, "events");
	endtask
	task automatic cmd(input logic [3:0] c);
		logic [31:0] r;
		apb(1, ADDR_COMMAND, {28'h0, c}, r);
		if (c[1] || c[2]) {blk_m.interrupt_enable_shadow, blk_m.movss} = 2'b00;
		if (c[3] && !ctl_m[1] && !ctl_m[2]) blk_m.nmi = 0;
		if (c[3] && ctl_m[1]) blk_m.vnmi = 0;
		if (c[1]) mtf_m = 0;
		@(posedge mclk_in);
		#1;
		chk(blk, blk_m, "cmd blocking");
		chk(monitor_trap, mtf_m, "mtf clear");
	endtask
	initial begin
		#1000000;
		error_cnt++;
		end_sim;
	end
	initial begin
		logic [31:0] r, info, ctl;
		r = $urandom(37384);
		repeat (5) @(posedge mclk_in);
		rst_n_in <= 1;
		apb(0, ADDR_CONTROLS, 0, r);
		chk(r, 32'h1, "ctl reset");
		apb(0, 12'h0fc, 0, r);
		chk(r, 0, "unmapped");
		for (int i = 0; i < 60; i++) begin
			info = $urandom & 32'h80000fff;
			if (i % 5 == 0) info = 32'h80000700;
			ctl = $urandom & 32'h3f;
			if (!ctl[2]) ctl[1] = 0;
			if (!ctl[0]) info[11] = 0;
			dlv <= 15'($urandom & 32'h7fff);
			bmap <= $urandom;
			ev <= 5'($urandom);
			entry(info, $urandom & 32'hf, 2'($urandom), ctl, $urandom & 32'hffff0);
			cmd(4'($urandom % 8 * 2) | {2'b00, mtf_m, 1'b0});
			$display("entry test %0d done", i);
		end
		end_sim;
	end
endmodule
`default_nettype wire
